// >>> common/sadc_pkg.sv
package sadc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 2;
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_RESULT = 2'h1;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int BIT_DONE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_CLKSEL = 5;
  localparam int BIT_DISABLE = 4;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] CH4_WRITE = 8'h04;

  // ----------------------------------------
  // Conversion timing in machine cycles
  // ----------------------------------------
  localparam int CONV_CYCLES = 46;
  localparam int SAMPLE_CYCLES = 4;
  localparam int CODE_BITS = 8;
  localparam int TRIAL_CYCLES = 5;
  localparam int FINISH_CYCLES = CONV_CYCLES - SAMPLE_CYCLES - CODE_BITS * TRIAL_CYCLES;
  localparam int CNT_W = 6;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_TRIAL,
    SADC_FINISH
  } sadc_state_t;

endpackage

// >>> common/sadc_sar_if.sv
interface sadc_sar_if;
  logic start;
  logic abort;
  logic cmp_high;
  logic busy;
  logic sampling;
  logic last;
  logic [7:0] dac;
  logic [7:0] code;

  modport eng (
    input start,
    input abort,
    input cmp_high,
    output busy,
    output sampling,
    output last,
    output dac,
    output code
  );

  modport ctl (
    output start,
    output abort,
    output cmp_high,
    input busy,
    input sampling,
    input last,
    input dac,
    input code
  );
endinterface

// >>> rtl/sadc_sar.sv
module sadc_sar (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  sadc_sar_if.eng sar
);
  import sadc_pkg::*;

  sadc_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [2:0] bit_idx;
  logic [7:0] trial;

  // ----------------------------------------
  // Phase end detection
  // ----------------------------------------
  logic phase_end;
  always_comb begin
    case (state)
      SADC_SAMPLE: phase_end = (cnt == CNT_W'(SAMPLE_CYCLES - 1));
      SADC_TRIAL: phase_end = (cnt == CNT_W'(TRIAL_CYCLES - 1));
      SADC_FINISH: phase_end = (cnt == CNT_W'(FINISH_CYCLES - 1));
      default: phase_end = 1'b0;
    endcase
  end

  assign sar.last = ce && (state == SADC_FINISH) && phase_end;
  assign trial = sar.cmp_high ? sar.dac : (sar.dac & ~(8'h01 << bit_idx));

  // ----------------------------------------
  // Successive approximation sequence
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= SADC_IDLE;
      cnt <= '0;
      bit_idx <= 3'h7;
      sar.dac <= 8'h00;
      sar.code <= 8'h00;
    end else if (ce) begin
      cnt <= phase_end ? '0 : cnt + CNT_W'(1);
      if (sar.abort) begin
        state <= SADC_IDLE;
        cnt <= '0;
      end else begin
        case (state)
          SADC_IDLE: begin
            cnt <= '0;
            if (sar.start) begin
              state <= SADC_SAMPLE;
            end
          end
          SADC_SAMPLE: begin
            if (phase_end) begin
              state <= SADC_TRIAL;
              bit_idx <= 3'h7;
              sar.dac <= 8'h80;
            end
          end
          SADC_TRIAL: begin
            // Keep the bit while the held input stays above the trial level
            if (phase_end) begin
              sar.dac <= trial | ((bit_idx == 3'h0) ? 8'h00 : (8'h01 << (bit_idx - 3'h1)));
              sar.code <= trial;
              bit_idx <= bit_idx - 3'h1;
              if (bit_idx == 3'h0) begin
                state <= SADC_FINISH;
              end
            end
          end
          SADC_FINISH: begin
            if (phase_end) begin
              state <= SADC_IDLE;
            end
          end
          default: state <= SADC_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sar.busy <= 1'b0;
      sar.sampling <= 1'b0;
    end else if (ce) begin
      sar.busy <= !sar.abort && ((state == SADC_IDLE) ? sar.start : !sar.last);
      sar.sampling <= !sar.abort && ((state == SADC_IDLE) ? sar.start :
                      (state == SADC_SAMPLE) && !phase_end);
    end
  end
endmodule

// >>> rtl/sadc_top.sv
// Functional notes
// - Eight inputs muxed, sampled, 8-bit SAR code
// - Control bits 2-0 choose the input channel; bit 3 is stored and read back only
// - Writing 04h selects channel four, clock zero
// - Writing start bit begins a conversion
// - Conversion takes exactly 46 machine cycles
// - Done flag bit 7 set at completion
// - Result register holds the 8-bit code
// - Reading result clears the done flag
// - Stop mode aborts a running conversion
// - Stop mode after completion keeps the result
module sadc_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [sadc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic stop_mode,
  input wire logic cmp_pin,
  output logic [2:0] ain_sel,
  output logic ain_enable,
  output logic sample_en,
  output logic [7:0] dac_code,
  output logic busy
);
  import sadc_pkg::*;

  // ----------------------------------------
  // Internal state
  // ----------------------------------------
  sadc_sar_if sar_bus ();

  logic [3:0] channel_select;
  logic clk_select;
  logic analog_input_disable;
  logic conversion_done_flag;
  logic [7:0] conversion_result;
  logic [2:0] cmp_sync;
  logic cmp_stable;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  function automatic logic hit(
    input logic strobe,
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] reg_addr
  );
    hit = strobe && (a == reg_addr);
  endfunction

  logic wr_ctrl;
  logic rd_ctrl;
  logic rd_result;
  logic start_ok;
  logic done;

  assign wr_ctrl = hit(wr, addr, REG_CONTROL);
  assign rd_ctrl = hit(rd, addr, REG_CONTROL);
  assign rd_result = hit(rd, addr, REG_RESULT);

  // Start is refused in stop mode and while a conversion runs
  assign start_ok = wr_ctrl && wdata[BIT_START] && !stop_mode && !sar_bus.busy;
  assign done = sar_bus.last && !stop_mode;

  assign sar_bus.start = start_ok;
  assign sar_bus.abort = stop_mode && sar_bus.busy;
  // An agreeing pair counts at once; the held copy only bridges a disagreement
  assign sar_bus.cmp_high = (cmp_sync[1] == cmp_sync[2]) ? cmp_sync[2] : cmp_stable;

  // ----------------------------------------
  // Comparator input synchroniser
  // ----------------------------------------
  // The comparator settles asynchronously; the trial length covers
  // the three-stage latency.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmp_sync <= 3'h0;
    end else if (ce) begin
      cmp_sync <= {cmp_sync[1:0], cmp_pin};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmp_stable <= 1'b0;
    end else if (ce && (cmp_sync[1] == cmp_sync[2])) begin
      cmp_stable <= cmp_sync[2];
    end
  end

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      channel_select <= CONTROL_RESET[SEL_HI:SEL_LO];
      clk_select <= CONTROL_RESET[BIT_CLKSEL];
      analog_input_disable <= CONTROL_RESET[BIT_DISABLE];
    end else if (ce && wr_ctrl) begin
      channel_select <= wdata[SEL_HI:SEL_LO];
      clk_select <= wdata[BIT_CLKSEL];
      analog_input_disable <= wdata[BIT_DISABLE];
    end
  end

  // ----------------------------------------
  // Completion flag
  // ----------------------------------------
  // Completion wins over a result read in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      conversion_done_flag <= CONTROL_RESET[BIT_DONE];
    end else if (ce) begin
      if (done) begin
        conversion_done_flag <= 1'b1;
      end else if (start_ok) begin
        conversion_done_flag <= 1'b0;
      end else if (rd_result) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Result register
  // ----------------------------------------
  // An aborted conversion leaves the old code, which software must
  // treat as undefined; a finished one is held through stop mode.
  always_ff @(posedge mclk) begin
    if (rst) begin
      conversion_result <= RESULT_RESET;
    end else if (ce && done) begin
      conversion_result <= sar_bus.code;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      if (rd_ctrl) begin
        // Start is a trigger only and never reads back
        rdata <= {conversion_done_flag, 1'b0, clk_select, analog_input_disable, channel_select};
      end else if (rd_result) begin
        rdata <= conversion_result;
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Analog front-end drive
  // ----------------------------------------
  // Only the low three select bits reach the eight-way mux
  always_ff @(posedge mclk) begin
    if (rst) begin
      ain_sel <= 3'h0;
      ain_enable <= 1'b0;
      sample_en <= 1'b0;
      dac_code <= 8'h00;
      busy <= 1'b0;
    end else if (ce) begin
      ain_sel <= wr_ctrl ? wdata[2:0] : channel_select[2:0];
      ain_enable <= wr_ctrl ? !wdata[BIT_DISABLE] : !analog_input_disable;
      sample_en <= sar_bus.sampling;
      dac_code <= sar_bus.dac;
      busy <= sar_bus.busy;
    end
  end

  sadc_sar u_sar (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .sar(sar_bus.eng)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Counts enabled busy cycles since the start was taken
  logic [CNT_W-1:0] run_cnt;
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_cnt <= '0;
    end else if (ce) begin
      if (start_ok) begin
        run_cnt <= '0;
      end else if (sar_bus.busy) begin
        run_cnt <= run_cnt + CNT_W'(1);
      end
    end
  end

  property p_conv_length;
    sar_bus.last |-> run_cnt == CNT_W'(CONV_CYCLES - 1);
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

  property p_flag_set;
    done && ce |=> conversion_done_flag && rdata == 8'h00 || conversion_done_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");

  property p_result_load;
    done && ce |=> conversion_result == $past(sar_bus.code);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  property p_read_clears;
    rd_result && ce && !done |=> !conversion_done_flag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear flag");

  property p_start;
    start_ok && ce |=> sar_bus.busy && !conversion_done_flag ##1 busy;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_start_reads_zero;
    rd_ctrl && ce |=> !rdata[BIT_START];
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero) else $error("start bit read back");

  property p_channel;
    wr_ctrl && ce |=> ain_sel == $past(wdata[2:0]) && ain_enable == !$past(wdata[BIT_DISABLE]);
  endproperty
  a_channel: assert property (p_channel) else $error("channel not routed");

  property p_ch4;
    wr_ctrl && ce && wdata == CH4_WRITE |=> ain_sel == 3'h4 && !clk_select;
  endproperty
  a_ch4: assert property (p_ch4) else $error("channel four write wrong");

  property p_abort;
    stop_mode && sar_bus.busy && ce |=> !sar_bus.busy && !conversion_done_flag;
  endproperty
  a_abort: assert property (p_abort) else $error("stop did not abort");

  property p_hold;
    stop_mode && conversion_done_flag |=> $stable(conversion_result);
  endproperty
  a_hold: assert property (p_hold) else $error("result lost in stop");

  property p_sample_first;
    start_ok && ce |=> sar_bus.sampling && sar_bus.dac == $past(sar_bus.dac);
  endproperty
  a_sample_first: assert property (p_sample_first) else $error("sampling did not begin");

  property p_sample_len;
    (start_ok && ce) ##1 (ce && !stop_mode) [*4] |=> !sar_bus.sampling;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling window wrong");

  property p_dac_first;
    (start_ok && ce) ##1 (ce && !stop_mode) [*4] |=> sar_bus.dac == 8'h80;
  endproperty
  a_dac_first: assert property (p_dac_first) else $error("first trial not at midscale");

  property p_sample_busy;
    sample_en |-> busy;
  endproperty
  a_sample_busy: assert property (p_sample_busy) else $error("sampling outside conversion");

  property p_last_drop;
    sar_bus.last |=> !sar_bus.busy;
  endproperty
  a_last_drop: assert property (p_last_drop) else $error("busy kept after completion");

  property p_last_busy;
    !sar_bus.busy |-> !sar_bus.last;
  endproperty
  a_last_busy: assert property (p_last_busy) else $error("completion while idle");

  property p_flag_stays;
    conversion_done_flag && !rd_result && !start_ok |=> conversion_done_flag;
  endproperty
  a_flag_stays: assert property (p_flag_stays) else $error("done flag lost");

  property p_flag_quiet;
    !conversion_done_flag && !done |=> !conversion_done_flag;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("done flag set without completion");

  property p_done_bit;
    rd_ctrl && ce |=> rdata[BIT_DONE] == $past(conversion_done_flag);
  endproperty
  a_done_bit: assert property (p_done_bit) else $error("done bit read wrong");

  property p_result_read;
    rd_result && ce |=> rdata == $past(conversion_result);
  endproperty
  a_result_read: assert property (p_result_read) else $error("result read wrong");

  property p_result_hold;
    !(done && ce) |=> $stable(conversion_result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without completion");

  property p_rdata_idle;
    ce && !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_unmapped;
    rd && ce && !rd_ctrl && !rd_result |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_ctrl_read;
    rd_ctrl && ce |=> rdata[SEL_HI:SEL_LO] == $past(channel_select) &&
      rdata[BIT_DISABLE] == $past(analog_input_disable);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control fields read wrong");

  property p_ain_hold;
    ce && !wr_ctrl |=> ain_sel == channel_select[2:0];
  endproperty
  a_ain_hold: assert property (p_ain_hold) else $error("channel route drifted");

  property p_abort_result;
    stop_mode && sar_bus.busy && ce |=> $stable(conversion_result);
  endproperty
  a_abort_result: assert property (p_abort_result) else $error("aborted conversion wrote result");

  property p_stop_refuse;
    wr_ctrl && stop_mode && ce |=> !sar_bus.busy;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse) else $error("conversion runs in stop mode");

endmodule

// >>> testbench/sadc_src_model.sv
module sadc_src_model (
  input wire logic mclk,
  input wire logic [2:0] ain_sel,
  input wire logic ain_enable,
  input wire logic [7:0] dac_code,
  input wire logic [7:0] level [8],
  output logic cmp_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Comparator seen from the source side
  // ----------------------------------------
  logic junk;

  initial junk = 1'b0;

  // A disabled path gives a changing level, so a stale value is never mistaken for a sample
  always @(posedge mclk) begin
    junk <= ~junk;
  end

  // Each level sits half a step above its code, so any trial at or below it reads high
  always_comb begin
    if (ain_enable) begin
      cmp_pin = (dac_code <= level[ain_sel]);
    end else begin
      cmp_pin = junk;
    end
  end
endmodule

// >>> testbench/sadc_top_tb.sv
module sadc_top_tb;
  import sadc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic stop_mode;
  logic cmp_pin;
  logic [2:0] ain_sel;
  logic ain_enable;
  logic sample_en;
  logic [7:0] dac_code;
  logic busy;
  logic [7:0] level [8];
  int mismatches;
  int checks_done;

  initial level = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h01, 8'h80, 8'h7f, 8'h3c};

  sadc_top u_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .stop_mode(stop_mode), .cmp_pin(cmp_pin), .ain_sel(ain_sel), .ain_enable(ain_enable),
    .sample_en(sample_en), .dac_code(dac_code), .busy(busy));

  sadc_src_model u_src (.mclk(mclk), .ain_sel(ain_sel), .ain_enable(ain_enable), .dac_code(dac_code),
    .level(level), .cmp_pin(cmp_pin));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_cnt(input int g, input int e);
    checks_done++;
    if (g != e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One idle cycle follows each access, so no strobe is set twice in one step
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk8(d, e);
  endtask

  // Starts a conversion and counts busy and sampling cycles over a window longer than it
  task automatic start_wait(input logic [2:0] ch);
    int nb;
    int ns;
    nb = 0;
    ns = 0;
    wr_reg(REG_CONTROL, {5'b01000, ch});
    repeat (60) begin
      @(negedge mclk);
      if (busy === 1'b1) nb++;
      if (sample_en === 1'b1) ns++;
    end
    chk_cnt(nb, CONV_CYCLES);
    chk_cnt(ns, SAMPLE_CYCLES);
    chk8({5'h00, ain_sel}, {5'h00, ch});
    chk8(dac_code, level[ch]);
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test();
  end

  initial begin
    mismatches = 0;
    checks_done = 0;
    rst = 1'b1;
    addr = '0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    stop_mode = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(REG_CONTROL, CONTROL_RESET);
    rd_chk(REG_RESULT, RESULT_RESET);
    wr_reg(REG_CONTROL, CH4_WRITE);
    rd_chk(REG_CONTROL, 8'h04);
    chk8({5'h00, ain_sel}, 8'h04);
    chk8({7'h00, ain_enable}, 8'h01);
    wr_reg(REG_CONTROL, 8'h34);
    rd_chk(REG_CONTROL, 8'h34);
    chk8({7'h00, ain_enable}, 8'h00);
    wr_reg(2'h3, 8'hff);
    rd_chk(2'h3, 8'h00);
    rd_chk(REG_CONTROL, 8'h34);
    for (int ch = 0; ch < 8; ch++) begin
      start_wait(3'(ch));
      rd_chk(REG_CONTROL, 8'h80 | 8'(ch));
      rd_chk(REG_RESULT, level[ch]);
      rd_chk(REG_CONTROL, 8'(ch));
    end
    start_wait(3'h2);
    wr_reg(REG_CONTROL, 8'h46);
    rd_chk(REG_CONTROL, 8'h06);
    repeat (60) @(posedge mclk);
    rd_chk(REG_RESULT, level[6]);
    start_wait(3'h3);
    stop_mode <= 1'b1;
    repeat (20) @(posedge mclk);
    stop_mode <= 1'b0;
    rd_chk(REG_CONTROL, 8'h83);
    rd_chk(REG_RESULT, level[3]);
    wr_reg(REG_CONTROL, 8'h45);
    repeat (10) @(posedge mclk);
    stop_mode <= 1'b1;
    @(negedge mclk);
    chk8({7'h00, busy}, 8'h01);
    repeat (5) @(negedge mclk);
    chk8({7'h00, busy}, 8'h00);
    repeat (50) @(posedge mclk);
    rd_chk(REG_CONTROL, 8'h05);
    wr_reg(REG_CONTROL, 8'h47);
    repeat (5) @(negedge mclk);
    chk8({7'h00, busy}, 8'h00);
    rd_chk(REG_CONTROL, 8'h07);
    stop_mode <= 1'b0;
    stop_test();
  end
endmodule
